// ==== core/cgm_pkg.sv ====
// cgm_pkg: constants, carriers and timing figures for the count-gate and
// marker front end.
// assumes one 100 MHz core clock; pin inputs are asynchronous to it.
package cgm_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 10;

  // marker pins
  localparam int NUM_MARKERS = 3;
  localparam int MARKER_CH_W = 2;

  // far-end hold time per marker level, and the same in core cycles
  // (a least time, so it rounds up)
  localparam int MARKER_HOLD_NS  = 100;
  localparam int MARKER_HOLD_CYC =
    (MARKER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser depth for every pin input
  localparam int SYNC_STAGES = 2;

  // record stream
  localparam int TAG_W      = 28;
  localparam int FIFO_DEPTH = 16;

  // reset values
  localparam logic             CE_SYNC_RESET     = 1'b1;
  localparam logic             MARKER_SYNC_RESET = 1'b0;
  localparam logic [TAG_W-1:0] TAG_RESET         = 28'h0000000;

  // static settings from the instrument's configuration logic
  typedef struct packed {
    logic timeTaggedRecordMode;  // 1: records go to the stream
    logic markerRisingEdge;      // 1: rising, 0: falling
  } cgm_cfg_t;

  // one entry of the time-tagged record stream
  typedef struct packed {
    logic                   isMarker;
    logic [MARKER_CH_W-1:0] channel;
    logic [TAG_W-1:0]       tag;
  } cgm_rec_t;

  localparam int REC_W = $bits(cgm_rec_t);

endpackage

// ==== core/cgm_fifo.sv ====
// cgm_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes one clock and a synchronous active-low reset; width and depth
// are parameters, depth need not be a power of two.
`timescale 1ns/1ps
`default_nettype none
module cgm_fifo #(
  parameter int WIDTH = cgm_pkg::REC_W,
  parameter int DEPTH = cgm_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire  logic             clk,
  input  wire  logic             reset_n,
  // filling side
  input  wire  logic             inValid,
  input  wire  logic [WIDTH-1:0] inData,
  output logic                   inReady,
  // draining side
  output logic                   outValid,
  output logic [WIDTH-1:0]       outData,
  input  wire  logic             outReady
);
  import cgm_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW-1:0]    wrPtr_reg, wrPtr_next;
  logic [AW-1:0]    rdPtr_reg, rdPtr_next;
  logic [CW-1:0]    count_reg, count_next;
  logic             valid_reg, valid_next;
  logic             full_reg, full_next;
  logic             push, pop;

  always_comb begin
    push       = inValid && !full_reg;
    pop        = valid_reg && outReady;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (push) begin
      wrPtr_next = (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
    end
    if (pop) begin
      rdPtr_next = (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    // flags registered so that both handshakes come from flip-flops
    valid_next = (count_next != '0);
    full_next  = (count_next == FULL);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      valid_reg <= 1'b0;
      full_reg  <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      full_reg  <= full_next;
    end
  end

  // storage needs no reset: nothing reads an entry before it is written
  always_ff @(posedge clk) begin
    if (push) begin
      memReg[wrPtr_reg] <= inData;
    end
  end

  assign inReady  = !full_reg;
  assign outValid = valid_reg;
  assign outData  = memReg[rdPtr_reg];

endmodule // cgm_fifo
`default_nettype wire

// ==== core/cgm_top.sv ====
// cgm_top: count-enable gate, marker edge capture and measurement-active
// output of the photon-timing front end.
// assumes pins are asynchronous; photon events, settings and the core
// activity level come from logic on clk.
//
// Functional notes
// - counts are recorded only while the count-enable input is high.
// - the count-enable gate applies in histogramming and time-tagged modes.
// - an open count-enable input reads as enabled; others hold it high.
// - with a router attached, count-enable carries its valid-count signal.
// - marker inputs pulled low, so open markers never make events.
// - marker active edge, rising or falling, chosen by a setting.
// - three markers, captured only in time-tagged record mode.
// - each detected marker edge adds one record to the stream, unless a record for the same marker still waits.
// - marker records beat photon records; photons may then be dropped.
// - measurement-active output high while the timing core runs.
// - the same logical signals appear on both connectors in parallel.
`timescale 1ns/1ps
`default_nettype none
module cgm_top (
  // clock and reset
  input  wire  logic                            clk,
  input  wire  logic                            reset_n,
  // settings and core state
  input  wire  cgm_pkg::cgm_cfg_t               cfg,
  input  wire  logic                            coreActive,
  // photon events from the timing core
  input  wire  logic                            photonValid,
  input  wire  logic [cgm_pkg::MARKER_CH_W-1:0] photonChannel,
  // connector pins, one logical net each
  input  wire  logic                            countEnablePin,
  input  wire  logic [cgm_pkg::NUM_MARKERS-1:0] markerPin,
  // connector outputs
  output logic                                  measActiveRouter,
  output logic                                  measActiveCtrl,
  // histogramming count pulses and the time-tagged lost-photon flag
  output logic                                  histCount,
  output logic [cgm_pkg::MARKER_CH_W-1:0]       histChannel,
  output logic                                  photonDropped,
  // record stream out
  output logic                                  recValid,
  output cgm_pkg::cgm_rec_t                     recData,
  input  wire  logic                            recReady
);
  import cgm_pkg::*;


  // synchronisers: stage one is read only by stage two
  logic                   ceS1_reg, ceS2_reg;
  logic [NUM_MARKERS-1:0] mkS1_reg, mkS2_reg, mkPrev_reg;
  logic [NUM_MARKERS-1:0] edgeRaw;

  // capture state
  logic [NUM_MARKERS-1:0] pend_reg, pend_next, grant;
  logic [TAG_W-1:0]       tag_reg, tag_next;
  logic                   measActive_reg, measActive_next;
  logic                   histCount_reg, histCount_next;
  logic [MARKER_CH_W-1:0] histChannel_reg, histChannel_next;
  logic                   dropped_reg, dropped_next;

  // record path into the buffer
  logic                   wrValid, wrReady;
  cgm_rec_t               wrData;
  logic [REC_W-1:0]       rdBits;
  logic                   gateOpen;
  logic                   photonForRec;

  // the open-pin level is supplied by the pull resistors outside the
  // logic; reset values match them so nothing fires at release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ceS1_reg <= CE_SYNC_RESET;
      ceS2_reg <= CE_SYNC_RESET;
    end else begin
      ceS1_reg <= countEnablePin;
      ceS2_reg <= ceS1_reg;
    end
  end

  generate
    for (genvar i = 0; i < NUM_MARKERS; i++) begin : g_marker
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          mkS1_reg[i]   <= MARKER_SYNC_RESET;
          mkS2_reg[i]   <= MARKER_SYNC_RESET;
          mkPrev_reg[i] <= MARKER_SYNC_RESET;
        end else begin
          mkS1_reg[i]   <= markerPin[i];
          mkS2_reg[i]   <= mkS1_reg[i];
          mkPrev_reg[i] <= mkS2_reg[i];
        end
      end
      // edge seen on the synchronised level only
      assign edgeRaw[i] = cfg.markerRisingEdge ?
                          (mkS2_reg[i] && !mkPrev_reg[i]) :
                          (!mkS2_reg[i] && mkPrev_reg[i]);
    end
  endgenerate

  // with a router attached the same pin is its valid-count line, so the
  // gate needs no separate path for it
  assign gateOpen = ceS2_reg;

  // lowest numbered pending marker goes first when the buffer has room
  always_comb begin
    grant = '0;
    if (wrReady) begin
      for (int i = 0; i < NUM_MARKERS; i++) begin
        if (pend_reg[i] && (grant == '0)) begin
          grant[i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    wrData          = '0;
    wrData.tag      = tag_reg;
    wrValid         = 1'b0;
    photonForRec    = cfg.timeTaggedRecordMode && gateOpen &&
                      photonValid;
    if (pend_reg != '0) begin
      // a waiting marker owns the slot even while the buffer is full
      wrValid         = 1'b1;
      wrData.isMarker = 1'b1;
      for (int i = NUM_MARKERS - 1; i >= 0; i--) begin
        if (pend_reg[i]) begin
          wrData.channel = MARKER_CH_W'(i);
        end
      end
    end else if (photonForRec) begin
      wrValid         = 1'b1;
      wrData.isMarker = 1'b0;
      wrData.channel  = photonChannel;
    end
  end

  always_comb begin
    tag_next         = tag_reg + 1'b1;
    measActive_next  = coreActive;
    histCount_next   = !cfg.timeTaggedRecordMode && gateOpen &&
                       photonValid;
    histChannel_next = histCount_next ? photonChannel : histChannel_reg;
    // photons have no back-pressure: lost when a marker or a full
    // buffer takes the slot
    dropped_next     = photonForRec &&
                       ((pend_reg != '0) || !wrReady);
    if (cfg.timeTaggedRecordMode) begin
      // a new edge wins over the grant that clears the same bit
      pend_next = (pend_reg & ~grant) | edgeRaw;
    end else begin
      pend_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tag_reg         <= TAG_RESET;
      pend_reg        <= '0;
      measActive_reg  <= 1'b0;
      histCount_reg   <= 1'b0;
      histChannel_reg <= '0;
      dropped_reg     <= 1'b0;
    end else begin
      tag_reg         <= tag_next;
      pend_reg        <= pend_next;
      measActive_reg  <= measActive_next;
      histCount_reg   <= histCount_next;
      histChannel_reg <= histChannel_next;
      dropped_reg     <= dropped_next;
    end
  end

  cgm_fifo #(
    .WIDTH (REC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (wrValid),
    .inData   (wrData),
    .inReady  (wrReady),
    .outValid (recValid),
    .outData  (rdBits),
    .outReady (recReady)
  );

  assign recData          = cgm_rec_t'(rdBits);
  assign measActiveRouter = measActive_reg;
  assign measActiveCtrl   = measActive_reg;
  assign histCount        = histCount_reg;
  assign histChannel      = histChannel_reg;
  assign photonDropped    = dropped_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_gated_photon;
    photonValid && gateOpen && !cfg.timeTaggedRecordMode;
  endsequence

  sequence s_rise_ch0;
    cfg.timeTaggedRecordMode && cfg.markerRisingEdge &&
    !mkPrev_reg[0] && mkS2_reg[0];
  endsequence

  sequence s_fall_ch0;
    cfg.timeTaggedRecordMode && !cfg.markerRisingEdge &&
    mkPrev_reg[0] && !mkS2_reg[0];
  endsequence

  sequence s_clash;
    photonValid && gateOpen && cfg.timeTaggedRecordMode &&
    (pend_reg != '0);
  endsequence

  a_gate_hist_cause: assert property (
    histCount |-> $past(photonValid) && $past(ceS2_reg) &&
                  !$past(cfg.timeTaggedRecordMode))
    else $error("count passed while the gate was closed");

  a_gate_time_tagged_record_mode_photon: assert property (
    (wrValid && !wrData.isMarker) |-> gateOpen && photonValid &&
                                      cfg.timeTaggedRecordMode)
    else $error("photon record written with gate closed");

  a_gate_open_hist: assert property (
    s_gated_photon |=> histCount && (histChannel == $past(photonChannel)))
    else $error("enabled count not recorded");

  a_quiet_marker: assert property (
    (!cfg.timeTaggedRecordMode ##1
     (mkS2_reg == '0 && mkPrev_reg == '0) [*3])
    |-> (pend_reg == '0))
    else $error("marker event from a steady low input");

  a_edge_rise: assert property (
    s_rise_ch0 |=> pend_reg[0])
    else $error("selected rising edge not captured");

  a_edge_fall: assert property (
    s_fall_ch0 |=> pend_reg[0])
    else $error("selected falling edge not captured");

  a_mode_ignore: assert property (
    !cfg.timeTaggedRecordMode |=> (pend_reg == '0))
    else $error("marker held outside time-tagged mode");

  a_marker_record: assert property (
    (pend_reg[1] && !pend_reg[0] && wrReady) |->
      wrValid && wrData.isMarker && (wrData.channel == 2'h1)
      ##1 !pend_reg[1] || $past(edgeRaw[1]))
    else $error("pending marker not written as a record");

  a_marker_priority: assert property (
    s_clash |=> photonDropped)
    else $error("photon not dropped behind a marker");

  a_meas_active: assert property (
    $rose(coreActive) |=> measActiveRouter && measActiveCtrl
                          ##1 (measActiveRouter == $past(coreActive)))
    else $error("measurement-active does not follow the core");

  a_sync_depth: assert property (
    $changed(ceS2_reg) |-> ceS2_reg == $past(countEnablePin, 2))
    else $error("count-enable not two stages behind the pin");

  // open inputs read as idle right after reset, so no false edge follows
  a_open_after_reset: assert property (
    !$past(reset_n) |-> gateOpen && (mkS2_reg == '0) && (pend_reg == '0))
    else $error("pin state after reset is not the open level");

  a_gate_closed: assert property (
    (photonValid && !gateOpen) |-> (!wrValid || wrData.isMarker)
      ##1 (!histCount && !photonDropped))
    else $error("photon passed a closed count-enable gate");

  a_hist_mode_only: assert property (
    cfg.timeTaggedRecordMode |=> !histCount)
    else $error("histogram count made in time-tagged mode");

  a_drop_full: assert property (
    (photonValid && gateOpen && cfg.timeTaggedRecordMode && !wrReady)
    |=> photonDropped)
    else $error("photon into a full buffer not flagged as lost");

  a_photon_kept: assert property (
    (photonValid && gateOpen && cfg.timeTaggedRecordMode && wrReady &&
     (pend_reg == '0)) |-> wrValid && !wrData.isMarker &&
      (wrData.channel == photonChannel) ##1 !photonDropped)
    else $error("photon lost although the slot was free");

  a_stream_hold: assert property (
    (recValid && !recReady) |=> recValid && $stable(recData))
    else $error("record changed before it was taken");

  a_meas_idle: assert property (
    !coreActive |=> !measActiveRouter && !measActiveCtrl)
    else $error("measurement-active high while the core is idle");

endmodule // cgm_top
`default_nettype wire

// ==== bench/cgm_scanner_model.sv ====
// cgm_scanner_model: external scanner driving count-enable and markers.
// assumes the bench asks for blanking by level and for marker flips by pulse.
`timescale 1ns/1ps
`default_nettype none
module cgm_scanner_model (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  // requests from the bench
  input  wire logic                            blankReq,
  input  wire logic [cgm_pkg::NUM_MARKERS-1:0] toggleReq,
  // pins
  output logic                                 countEnablePin,
  output logic [cgm_pkg::NUM_MARKERS-1:0]      markerPin
);
  import cgm_pkg::*;
  int holdCnt [NUM_MARKERS];

  // pins get their first level at the first edge, while reset still holds
  always @(posedge clk) begin
    // high unless blanking, as a router-free scanner must
    countEnablePin <= !blankReq;
    for (int i = 0; i < NUM_MARKERS; i++) begin
      if (!reset_n) begin
        markerPin[i] <= 1'b0;
        holdCnt[i]   <= 0;
      end else if (toggleReq[i] && holdCnt[i] >= MARKER_HOLD_CYC) begin
        // a flip too early is dropped, never sent short
        markerPin[i] <= !markerPin[i];
        holdCnt[i]   <= 1;
      end else if (holdCnt[i] < 1000) begin
        holdCnt[i] <= holdCnt[i] + 1;
      end
    end
  end
endmodule // cgm_scanner_model
`default_nettype wire

// ==== bench/tb_cgm_top.sv ====
// tb_cgm_top: self-checking bench for the count gate and marker front end.
// assumes the scanner model drives the pins; records drained by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_cgm_top;
  import cgm_pkg::*;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  cgm_cfg_t               cfg = '0;
  logic                   coreActive = 1'b0;
  logic                   photonValid = 1'b0;
  logic [MARKER_CH_W-1:0] photonChannel = '0;
  logic                   recReady = 1'b0;
  logic                   blankReq = 1'b0;
  logic [NUM_MARKERS-1:0] toggleReq = '0;
  logic                   countEnablePin;
  logic [NUM_MARKERS-1:0] markerPin;
  logic                   measActiveRouter;
  logic                   measActiveCtrl;
  logic                   histCount;
  logic [MARKER_CH_W-1:0] histChannel;
  logic                   photonDropped;
  logic                   recValid;
  cgm_rec_t               recData;
  cgm_rec_t               r;
  int                     nErrors = 0;
  int                     numChecks = 0;

  always #5 clk = ~clk;

  cgm_top dut (.clk(clk), .reset_n(reset_n), .cfg(cfg),
    .coreActive(coreActive), .photonValid(photonValid),
    .photonChannel(photonChannel), .countEnablePin(countEnablePin),
    .markerPin(markerPin), .measActiveRouter(measActiveRouter),
    .measActiveCtrl(measActiveCtrl), .histCount(histCount),
    .histChannel(histChannel), .photonDropped(photonDropped),
    .recValid(recValid), .recData(recData), .recReady(recReady));

  cgm_scanner_model scanner (.clk(clk), .reset_n(reset_n),
    .blankReq(blankReq), .toggleReq(toggleReq),
    .countEnablePin(countEnablePin), .markerPin(markerPin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp;
    $display("checks=%0d mismatches=%0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // outputs of the taking edge are settled on return
  task automatic photon(input logic [MARKER_CH_W-1:0] ch);
    @(posedge clk);
    photonValid   <= 1'b1;
    photonChannel <= ch;
    @(posedge clk);
    photonValid <= 1'b0;
    #1;
  endtask

  // spaced beyond the far-end hold time so no flip is lost
  task automatic toggle(input int i);
    @(posedge clk);
    toggleReq <= NUM_MARKERS'(1) << i;
    @(posedge clk);
    toggleReq <= '0;
    tick(14);
  endtask

  task automatic setBlank(input logic b);
    @(posedge clk);
    blankReq <= b;
    tick(6);
  endtask

  task automatic pop(output cgm_rec_t rec);
    int k = 0;
    while (recValid !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    check(recValid, 1'b1);
    rec = recData;
    @(posedge clk);
    recReady <= 1'b1;
    @(posedge clk);
    recReady <= 1'b0;
    #1;
  endtask

  task automatic setMode(input logic time_tagged_record_mode, input logic rising);
    @(posedge clk);
    cfg.timeTaggedRecordMode <= time_tagged_record_mode;
    cfg.markerRisingEdge     <= rising;
    tick(2);
  endtask

  task automatic testMeas;
    @(posedge clk);
    coreActive <= 1'b1;
    tick(1);
    check(measActiveRouter, 1'b1);
    check(measActiveCtrl, 1'b1);
    @(posedge clk);
    coreActive <= 1'b0;
    tick(1);
    check(measActiveRouter, 1'b0);
    check(measActiveCtrl, 1'b0);
    $display("test meas done");
  endtask

  task automatic testHist;
    setMode(1'b0, 1'b1);
    photon(2'h2);
    check(histCount, 1'b1);
    check(histChannel, 2'h2);
    tick(1);
    check(histCount, 1'b0);
    setBlank(1'b1);
    photon(2'h1);
    check(histCount, 1'b0);
    setBlank(1'b0);
    $display("test hist done");
  endtask

  task automatic testTagged;
    setMode(1'b1, 1'b1);
    photon(2'h3);
    check(photonDropped, 1'b0);
    check(histCount, 1'b0);
    pop(r);
    check(r.isMarker, 1'b0);
    check(r.channel, 2'h3);
    setBlank(1'b1);
    photon(2'h0);
    check(photonDropped, 1'b0);
    tick(5);
    check(recValid, 1'b0);
    setBlank(1'b0);
    $display("test tagged done");
  endtask

  // two flips per channel: only the selected direction yields a record
  task automatic testMarkers;
    for (int e = 1; e >= 0; e--) begin
      setMode(1'b1, e[0]);
      for (int i = 0; i < NUM_MARKERS; i++) begin
        toggle(i);
        toggle(i);
        pop(r);
        check(r.isMarker, 1'b1);
        check(r.channel, i[1:0]);
        check(recValid, 1'b0);
      end
    end
    setMode(1'b0, 1'b1);
    toggle(0);
    toggle(0);
    check(recValid, 1'b0);
    setMode(1'b1, 1'b1);
    tick(5);
    check(recValid, 1'b0);
    $display("test markers done");
  endtask

  // full buffer with a marker waiting: one photon lost, marker kept
  task automatic testPriority;
    logic [TAG_W-1:0] prevTag;
    prevTag = '0;
    for (int j = 0; j < FIFO_DEPTH; j++) begin
      photon(2'(j));
      check(photonDropped, 1'b0);
    end
    toggle(2);
    photon(2'h1);
    check(photonDropped, 1'b1);
    for (int j = 0; j < FIFO_DEPTH; j++) begin
      pop(r);
      check({r.isMarker, r.channel}, {1'b0, 2'(j)});
      // photons went in every second cycle, so their tags are two apart
      if (j > 0) begin
        check(TAG_W'(r.tag - prevTag), 28'h0000002);
      end
      prevTag = r.tag;
    end
    pop(r);
    check({r.isMarker, r.channel}, 3'h6);
    toggle(2);
    check(recValid, 1'b0);
    $display("test priority done");
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    $display("watchdog expired");
    wrapUp();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(2);
    check({measActiveRouter, histCount, recValid}, 3'h0);
    testMeas();
    testHist();
    testTagged();
    testMarkers();
    testPriority();
    wrapUp();
  end
endmodule // tb_cgm_top
`default_nettype wire
